// File: bscb_pkg.sv
// Package with register map, field positions and reset values for the block.
// Summary of operation
// - With master-abort mode 0, secondary master aborts are not reported, aborted reads return all ones and aborted write data is dropped.
// - With master-abort mode 1, a secondary master abort signals target abort where allowed, otherwise raises system error if enabled.
// - The secondary interface reset bit forces both secondary reset pins asserted while 1 and resets to 0.
// - Fast back-to-back to different secondary targets is allowed only while its enable bit is 1, reset 0.
// - Bits 24 and 25 are plain read/write storage resetting to 0 with no effect.
// - A primary or secondary master timeout sets a sticky flag at bit 26, cleared by writing one, reset 0.
// - A primary or secondary discard timer expiry sets a sticky flag at bit 27 and asserts system error, cleared by writing one.
// - Bits 31 to 28 read as zero and reset to zero.
package bscb_pkg;
  // ----------------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------------
  localparam logic [7:0] BSCB_CTRL_OFS = 8'h3C;
  localparam logic [7:0] BSCB_IMASK_OFS = 8'h44;
  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int BSCB_MA_MODE_BIT = 21;
  localparam int BSCB_SEC_RST_BIT = 22;
  localparam int BSCB_FBB_BIT = 23;
  localparam int BSCB_RSV0_BIT = 24;
  localparam int BSCB_RSV1_BIT = 25;
  localparam int BSCB_MTO_BIT = 26;
  localparam int BSCB_DT_BIT = 27;
  // ----------------------------------------------------------------------
  // Reset values and constants
  // ----------------------------------------------------------------------
  localparam logic [31:0] BSCB_CTRL_RESET = 32'h0000_0000;
  localparam logic [31:0] BSCB_IMASK_RESET = 32'h0000_0000;
  localparam logic [31:0] BSCB_ALL_ONES = 32'hFFFF_FFFF;
endpackage : bscb_pkg

// File: bscb_top.sv
// Bridge control upper bits with APB access, abort handling and flags.
//
// The APB register port and the register offsets were chosen for this implementation.
`timescale 1ns/1ns
module bscb_top
  import bscb_pkg::*;
(
  // APB clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Bridge event inputs, one-cycle pulses, and the system error reporting enable level
  input wire logic pri_mto_expire,
  input wire logic sec_mto_expire,
  input wire logic pri_dt_expire,
  input wire logic sec1_dt_expire,
  input wire logic sec2_dt_expire,
  input wire logic serr_report_en,
  // Secondary master abort handling
  input wire logic sec_master_abort,
  input wire logic abort_is_read,
  input wire logic target_abort_possible,
  output logic signal_target_abort,
  output logic abort_drop_write,
  output logic [31:0] abort_read_data,
  // Pins and controls
  output logic primary_system_error_n,
  output logic first_secondary_reset_n,
  output logic second_secondary_reset_n,
  output logic fbb_allowed,
  output logic irq
);
  import bscb_pkg::*;

  logic ma_mode, sec_rst, fbb, mto, dt;
  logic [1:0] rsv;
  logic [1:0] imask;
  logic next_ma_mode, next_sec_rst, next_fbb, next_mto, next_dt;
  logic [1:0] next_rsv, next_imask;
  logic wr_en, rd_en, hit_ctrl, hit_imask;
  logic [31:0] next_prdata;
  logic next_ta, next_drop, next_serr;
  logic [31:0] next_ard;
  logic mto_evt, dt_evt;

  // --------------------------------------------------------------------
  // Bus decode
  // --------------------------------------------------------------------
  // Zero wait state slave: every access phase completes at once.
  assign pready = 1'b1;
  assign pslverr = 1'b0;
  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && !penable && !pwrite;
  assign hit_ctrl = (paddr == BSCB_CTRL_OFS);
  assign hit_imask = (paddr == BSCB_IMASK_OFS);
  assign mto_evt = pri_mto_expire || sec_mto_expire;
  assign dt_evt = pri_dt_expire || sec1_dt_expire || sec2_dt_expire;

  // --------------------------------------------------------------------
  // Register next values
  // --------------------------------------------------------------------
  // Writes update control bits; hardware sets of flags win over clears.
  always_comb
  begin
    next_ma_mode = ma_mode;
    next_sec_rst = sec_rst;
    next_fbb = fbb;
    next_rsv = rsv;
    next_imask = imask;
    next_mto = mto;
    next_dt = dt;
    if (wr_en && hit_ctrl)
    begin
      next_ma_mode = pwdata[BSCB_MA_MODE_BIT];
      next_sec_rst = pwdata[BSCB_SEC_RST_BIT];
      next_fbb = pwdata[BSCB_FBB_BIT];
      next_rsv = pwdata[BSCB_RSV1_BIT:BSCB_RSV0_BIT];
      if (pwdata[BSCB_MTO_BIT])
        next_mto = 1'b0;
      if (pwdata[BSCB_DT_BIT])
        next_dt = 1'b0;
    end
    if (wr_en && hit_imask)
      next_imask = pwdata[BSCB_DT_BIT:BSCB_MTO_BIT];
    if (mto_evt)
      next_mto = 1'b1;
    if (dt_evt)
      next_dt = 1'b1;
  end

  // Read data is captured in the setup phase and held through access.
  always_comb
  begin
    next_prdata = prdata;
    if (rd_en)
    begin
      next_prdata = 32'h0000_0000;
      if (hit_ctrl)
      begin
        next_prdata[BSCB_MA_MODE_BIT] = ma_mode;
        next_prdata[BSCB_SEC_RST_BIT] = sec_rst;
        next_prdata[BSCB_FBB_BIT] = fbb;
        next_prdata[BSCB_RSV1_BIT:BSCB_RSV0_BIT] = rsv;
        next_prdata[BSCB_MTO_BIT] = mto;
        next_prdata[BSCB_DT_BIT] = dt;
      end
      else if (hit_imask)
        next_prdata[BSCB_DT_BIT:BSCB_MTO_BIT] = imask;
    end
  end

  // --------------------------------------------------------------------
  // Abort response
  // --------------------------------------------------------------------
  // Picks target abort, system error or silent completion per mode.
  always_comb
  begin
    next_ta = 1'b0;
    next_drop = 1'b0;
    next_ard = 32'h0000_0000;
    next_serr = dt_evt;
    if (sec_master_abort)
    begin
      if (!ma_mode)
      begin
        next_drop = !abort_is_read;
        next_ard = abort_is_read ? BSCB_ALL_ONES : 32'h0000_0000;
      end
      else if (target_abort_possible)
        next_ta = 1'b1;
      else if (serr_report_en)
        next_serr = 1'b1;
    end
  end

  // --------------------------------------------------------------------
  // State registers
  // --------------------------------------------------------------------
  // All control state clears to zero under reset.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ma_mode <= 1'b0;
      sec_rst <= 1'b0;
      fbb <= 1'b0;
      rsv <= 2'h0;
      mto <= 1'b0;
      dt <= 1'b0;
      imask <= 2'h0;
      prdata <= BSCB_CTRL_RESET;
      signal_target_abort <= 1'b0;
      abort_drop_write <= 1'b0;
      abort_read_data <= 32'h0000_0000;
      primary_system_error_n <= 1'b1;
    end
    else
    begin
      ma_mode <= next_ma_mode;
      sec_rst <= next_sec_rst;
      fbb <= next_fbb;
      rsv <= next_rsv;
      mto <= next_mto;
      dt <= next_dt;
      imask <= next_imask;
      prdata <= next_prdata;
      signal_target_abort <= next_ta;
      abort_drop_write <= next_drop;
      abort_read_data <= next_ard;
      primary_system_error_n <= !next_serr;
    end
  end

  // Secondary reset pins and fast back-to-back follow the control bits.
  assign first_secondary_reset_n = !sec_rst;
  assign second_secondary_reset_n = !sec_rst;
  assign fbb_allowed = fbb;
  assign irq = (mto && imask[0]) || (dt && imask[1]);

  // --------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------
  sequence s_ctrl_write;
    psel && penable && pwrite && (paddr == BSCB_CTRL_OFS);
  endsequence

  a_abort_all_ones: assert property (@(posedge pclk) disable iff (!presetn)
    sec_master_abort && !ma_mode && abort_is_read |=>
    abort_read_data == 32'hFFFF_FFFF && !signal_target_abort)
    else $error("aborted read did not return all ones");
  a_abort_target: assert property (@(posedge pclk) disable iff (!presetn)
    sec_master_abort && ma_mode && target_abort_possible |=>
    signal_target_abort && !abort_drop_write)
    else $error("target abort not signalled");
  a_abort_serr: assert property (@(posedge pclk) disable iff (!presetn)
    sec_master_abort && ma_mode && !target_abort_possible
    && serr_report_en |=> !primary_system_error_n)
    else $error("system error not raised on abort");
  a_sec_reset_pins: assert property (@(posedge pclk) disable iff (!presetn)
    s_ctrl_write ##1 1'b1 |-> first_secondary_reset_n
    == !$past(pwdata[22]) && second_secondary_reset_n
    == first_secondary_reset_n)
    else $error("secondary reset pins disagree with bit");
  a_sec_reset_hold: assert property (@(posedge pclk) disable iff (!presetn)
    !first_secondary_reset_n && !s_ctrl_write |=>
    !first_secondary_reset_n)
    else $error("secondary reset released early");
  a_fbb_follow: assert property (@(posedge pclk) disable iff (!presetn)
    s_ctrl_write |=> fbb_allowed == $past(pwdata[23]))
    else $error("fast back-to-back enable not updated");
  a_mto_set: assert property (@(posedge pclk) disable iff (!presetn)
    pri_mto_expire || sec_mto_expire |=> mto)
    else $error("master timeout flag not set");
  a_dt_serr: assert property (@(posedge pclk) disable iff (!presetn)
    pri_dt_expire || sec1_dt_expire || sec2_dt_expire |=>
    dt && !primary_system_error_n)
    else $error("discard timer flag or system error missing");
  a_rsv_zero: assert property (@(posedge pclk) disable iff (!presetn)
    prdata[31:28] == 4'h0 && prdata[20:0] == 21'h0)
    else $error("reserved read bits not zero");
  a_rsv_store: assert property (@(posedge pclk) disable iff (!presetn)
    s_ctrl_write |=> rsv == $past(pwdata[25:24]))
    else $error("reserved storage bits not written");

  // --------------------------------------------------------------------
  // Flag, abort, mode and hold assertions
  // --------------------------------------------------------------------
  // A write of one to the master timeout flag with no event that cycle.
  sequence s_mto_clear;
    s_ctrl_write && pwdata[BSCB_MTO_BIT] && !mto_evt;
  endsequence

  // A write of one to the discard timer flag with no event that cycle.
  sequence s_dt_clear;
    s_ctrl_write && pwdata[BSCB_DT_BIT] && !dt_evt;
  endsequence

  // The timeout flag stays set until software writes a one to it.
  a_mto_sticky: assert property (@(posedge pclk) disable iff (!presetn)
    mto && !(s_ctrl_write && pwdata[26]) |=> mto)
    else $error("master timeout flag lost without a clear");

  // A clearing write with no event that cycle drops the timeout flag.
  a_mto_clear: assert property (@(posedge pclk) disable iff (!presetn)
    s_mto_clear |=> !mto)
    else $error("master timeout flag not cleared");

  // The discard flag stays set until software writes a one to it.
  a_dt_sticky: assert property (@(posedge pclk) disable iff (!presetn)
    dt && !(s_ctrl_write && pwdata[27]) |=> dt)
    else $error("discard timer flag lost without a clear");

  // A clearing write with no event that cycle drops the discard flag.
  a_dt_clear: assert property (@(posedge pclk) disable iff (!presetn)
    s_dt_clear |=> !dt)
    else $error("discard timer flag not cleared");

  // An aborted write in mode zero is dropped with no read data or abort.
  a_abort_drop: assert property (@(posedge pclk) disable iff (!presetn)
    sec_master_abort && !ma_mode && !abort_is_read |=>
    abort_drop_write && abort_read_data == 32'h0 && !signal_target_abort)
    else $error("aborted write not dropped silently");

  // Mode zero never reports an abort on the system error pin.
  a_abort_quiet: assert property (@(posedge pclk) disable iff (!presetn)
    sec_master_abort && !ma_mode && !dt_evt |=>
    primary_system_error_n && !signal_target_abort)
    else $error("abort reported in silent mode");

  // System error stays high when no abort and no discard expiry come.
  a_serr_idle: assert property (@(posedge pclk) disable iff (!presetn)
    !sec_master_abort && !dt_evt |=> primary_system_error_n)
    else $error("system error raised without a cause");

  // With no abort, the abort outputs stay quiet.
  a_abort_idle: assert property (@(posedge pclk) disable iff (!presetn)
    !sec_master_abort |=> !signal_target_abort && !abort_drop_write
    && abort_read_data == 32'h0)
    else $error("abort outputs active without an abort");

  // The reporting mode bit takes the written value.
  a_mode_store: assert property (@(posedge pclk) disable iff (!presetn)
    s_ctrl_write |=> ma_mode == $past(pwdata[21]))
    else $error("abort mode bit not written");

  // Fast back-to-back permission changes only on a control write.
  a_fbb_hold: assert property (@(posedge pclk) disable iff (!presetn)
    !s_ctrl_write |=> $stable(fbb_allowed))
    else $error("fast back-to-back enable changed without a write");

  // Both secondary reset pins change only on a control write.
  a_rst_pin_hold: assert property (@(posedge pclk) disable iff (!presetn)
    !s_ctrl_write |=> $stable(first_secondary_reset_n)
    && $stable(second_secondary_reset_n))
    else $error("secondary reset pins changed without a write");

  // The reserved storage bits change only on a control write.
  a_rsv_hold: assert property (@(posedge pclk) disable iff (!presetn)
    !s_ctrl_write |=> $stable(rsv))
    else $error("reserved storage bits changed without a write");
endmodule : bscb_top

// File: bscb_far.sv
// Far-side model: primary and secondary timer events and abort requests.
`timescale 1ns/1ns
module bscb_far
(
  // Clock
  input wire logic pclk,
  // Event pulses, abort qualifiers and error reporting enable
  output logic [4:0] ev,
  output logic [2:0] ab,
  output logic serr_en
);
  // Raises the requested pulses for exactly one clock cycle.
  task automatic fire(input logic [4:0] e, input logic [2:0] a);
    ev <= e;
    ab <= a;
    @(posedge pclk);
    ev <= 5'h00;
    ab <= 3'h0;
  endtask : fire
  // Idle lines with reporting enabled.
  initial
  begin
    ev = 5'h00;
    ab = 3'h0;
    serr_en = 1'b1;
  end
endmodule : bscb_far

// File: bscb_bench.sv
// Self-checking testbench for the bridge control upper bits.
`timescale 1ns/1ns
module bscb_bench;
  import bscb_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata, rd, ard;
  logic pready, slverr, sta, adw, serr_n, rst1_n, rst2_n, fbb, irq;
  logic [4:0] ev;
  logic [2:0] ab;
  logic serr_en;
  int n_fail = 0;
  int samples_checked = 0;
  // Clock of 8 ns period.
  always #4 pclk = ~pclk;
  bscb_far far (.pclk(pclk), .ev(ev), .ab(ab), .serr_en(serr_en));
  bscb_top dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(slverr),
    .pri_mto_expire(ev[0]),
    .sec_mto_expire(ev[1]), .pri_dt_expire(ev[2]), .sec1_dt_expire(ev[3]),
    .sec2_dt_expire(ev[4]), .serr_report_en(serr_en),
    .sec_master_abort(ab[0]), .abort_is_read(ab[1]),
    .target_abort_possible(ab[2]), .signal_target_abort(sta),
    .abort_drop_write(adw), .abort_read_data(ard),
    .primary_system_error_n(serr_n), .first_secondary_reset_n(rst1_n),
    .second_secondary_reset_n(rst2_n), .fbb_allowed(fbb), .irq(irq));
  // Compares one value and counts the outcome.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // One APB transfer; read data lands in rd.
  task automatic xfer(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : xfer
  // Prints the counts and the verdict, then stops.
  task automatic final_report;
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : final_report
  // Reset values, read/write storage, reset pins and unmapped space.
  task automatic t_regs;
    xfer(1'b0, BSCB_CTRL_OFS, 32'h0);
    chk(rd, BSCB_CTRL_RESET);
    chk({rst1_n, rst2_n, fbb, irq}, 32'hC);
    xfer(1'b1, BSCB_CTRL_OFS, 32'hFFFF_FFFF);
    xfer(1'b0, BSCB_CTRL_OFS, 32'h0);
    chk(rd, 32'h03E0_0000);
    repeat (4) @(posedge pclk);
    chk({rst1_n, rst2_n, fbb}, 32'h1);
    xfer(1'b1, BSCB_CTRL_OFS, 32'h0);
    chk({rst1_n, rst2_n, fbb}, 32'h6);
    xfer(1'b1, 8'h10, 32'hFFFF_FFFF);
    xfer(1'b0, 8'h10, 32'h0);
    chk(rd, 32'h0);
    chk({pready, slverr}, 32'h2);
    $display("test regs done");
  endtask : t_regs
  // Every timer event sets its flag, raises irq and is cleared.
  task automatic t_events;
    xfer(1'b1, BSCB_IMASK_OFS, 32'h0C00_0000);
    for (int i = 0; i < 5; i++)
    begin
      far.fire(5'(1 << i), 3'h0);
      #1;
      chk(serr_n, (i < 2) ? 32'h1 : 32'h0);
      chk(irq, 32'h1);
      @(posedge pclk);
      xfer(1'b0, BSCB_CTRL_OFS, 32'h0);
      chk(rd, (i < 2) ? 32'h0400_0000 : 32'h0800_0000);
      xfer(1'b1, BSCB_CTRL_OFS, rd);
      chk(irq, 32'h0);
    end
    xfer(1'b1, BSCB_IMASK_OFS, 32'h0);
    far.fire(5'h01, 3'h0);
    #1;
    chk(irq, 32'h0);
    @(posedge pclk);
    xfer(1'b1, BSCB_CTRL_OFS, 32'h0400_0000);
    xfer(1'b0, BSCB_CTRL_OFS, 32'h0);
    chk(rd, 32'h0);
    $display("test events done");
  endtask : t_events
  // Aborted reads and writes in mode zero, aborted reads only in mode one.
  task automatic t_abort;
    far.fire(5'h00, 3'b011);
    #1;
    chk(ard, BSCB_ALL_ONES);
    chk({sta, serr_n}, 32'h1);
    @(posedge pclk);
    far.fire(5'h00, 3'b001);
    #1;
    chk({sta, adw, serr_n}, 32'h3);
    @(posedge pclk);
    xfer(1'b1, BSCB_CTRL_OFS, 32'h0020_0000);
    far.fire(5'h00, 3'b111);
    #1;
    chk({sta, adw, serr_n}, 32'h5);
    chk(ard, 32'h0);
    @(posedge pclk);
    far.fire(5'h00, 3'b011);
    #1;
    chk({sta, serr_n}, 32'h0);
    @(posedge pclk);
    $display("test abort done");
  endtask : t_abort
  // Main sequence after two cycles of reset.
  initial
  begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_regs;
    t_events;
    t_abort;
    final_report;
  end
  // Watchdog against a hang.
  initial
  begin
    #20000;
    n_fail++;
    final_report;
  end
endmodule : bscb_bench
